// *** pkg/flash_wp_pkg.sv ***
// Shared constants and types of the flash write-protection block
package flash_wp_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int PUW_TIME_US   = 10;   // power-up write inhibit delay
  localparam int RST_TIME_US   = 30;   // software reset period
  localparam int PROG_TIME_NS  = 2000;
  localparam int ERASE_TIME_NS = 5000;
  localparam int WRSR_TIME_NS  = 1000;
  localparam int PUW_CYC       = (PUW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC_DEF   = (RST_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_CYC_DEF  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRSR_CYC_DEF  = (WRSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // instruction codes
  // ****************************************************************
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_BE      = 8'hD8;
  localparam logic [7:0] OP_CE      = 8'hC7;
  localparam logic [7:0] OP_CE_ALT  = 8'h60;
  localparam logic [7:0] OP_ERSEC   = 8'h44;
  localparam logic [7:0] OP_PRSEC   = 8'h42;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  localparam logic [7:0] OP_WRSR3   = 8'h11;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_RDSR3   = 8'h15;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7A;
  localparam logic [7:0] OP_PDOWN   = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_UNLOCK  = 8'h39;
  localparam logic [7:0] OP_RSTEN   = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;

  // ****************************************************************
  // status bit positions and array geometry
  // ****************************************************************
  localparam int BUSY_POS = 0;   // status one
  localparam int WEL_POS  = 1;
  localparam int BP_LSB   = 2;
  localparam int TB_POS   = 6;
  localparam int SRP_POS  = 7;
  localparam int SRL_POS  = 0;   // status two
  localparam int CMP_POS  = 6;
  localparam int SUS_POS  = 7;
  localparam int WPS_POS  = 2;   // status three
  localparam int ADDR_W       = 25;
  localparam int LOCK_BLOCKS  = 510;
  localparam int LOCK_SECTORS = 32;
  localparam int LOCK_BITS    = LOCK_BLOCKS + LOCK_SECTORS;
  localparam int BLOCKS_ALL   = 512;
  localparam int SECT_PER_BLK = 16;
  localparam int BP_ALL       = 10;  // field value from which the whole array is covered

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       protect_scheme_select;
    logic       cmp;
    logic       status_lockdown_bit;
    logic       status_protect_bit;
    logic       tb;
    logic [3:0] bp;
  } protCfg_t;
  localparam protCfg_t PROT_RESET = '0;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic mosi;
    logic wpN;
  } pinSet_t;

  typedef enum logic [4:0] {
    MODE_READY = 5'h01,
    MODE_BUSY  = 5'h02,
    MODE_SUSP  = 5'h04,
    MODE_PDOWN = 5'h08,
    MODE_RESET = 5'h10
  } mode_t;

endpackage : flash_wp_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0   // idle level of each pin, avoids false edges
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** rtl/flash_write_protect_status.sv ***
// Write protection, busy and status logic of a serial flash device
// Function
// - in power-on reset nothing executes
// - inhibit enable and writes after reset delay
// - write enable latch cleared at power-up
// - writes refused without write enable latch
// - write enable sets latch, read-only bit one
// - disable and every write clear latch
// - busy bit zero set during operations
// - busy accepts only status read, suspend
// - power-down accepts only release
// - lock bits: 510 blocks, 32 sectors
// - locked region ignores erase and program
// - all lock bits set at power-on
// - unlock instruction clears one lock bit
// - scheme select picks fields or locks
// - block protect field in bits 5..2
// - top/bottom bit picks range origin
// - complement bit inverts protected range
// - status writes gated by protect bits, pin
// - protect bit with low pin blocks status writes
// - software reset sets all lock bits
`timescale 1ns/1ps
`default_nettype none
module flash_write_protect_status
  import flash_wp_pkg::*;
#(
  parameter int PROG_CYC  = PROG_CYC_DEF,
  parameter int ERASE_CYC = ERASE_CYC_DEF,
  parameter int WRSR_CYC  = WRSR_CYC_DEF,
  parameter int RST_CYC   = RST_CYC_DEF
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // serial pins
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       wpN,
  output var  logic       miso,
  // observation
  output var  logic [7:0] statusOne,
  output var  logic       powerDown
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // lock bit index of an address: inner blocks first, then sectors
  function automatic logic [9:0] regionIndex(input logic [ADDR_W-1:0] a);
    logic [8:0] blk;
    logic [9:0] sec;
    blk = a[ADDR_W-1:16];
    sec = {6'h0, a[15:12]};
    if (blk == 9'h000) return 10'(LOCK_BLOCKS) + sec;
    if (blk == 9'(BLOCKS_ALL - 1)) return 10'(LOCK_BLOCKS + SECT_PER_BLK) + sec;
    return {1'b0, blk} - 10'h001;
  endfunction : regionIndex

  // number of 64KB blocks covered by the block protect field
  function automatic logic [9:0] spanBlocks(input logic [3:0] bp);
    if (bp == 4'h0) return 10'h000;
    if (bp >= 4'(BP_ALL)) return 10'(BLOCKS_ALL);
    return 10'h001 << (bp - 4'h1);
  endfunction : spanBlocks

  // range protection of one block under the field scheme
  function automatic logic bpProt(input logic [8:0] blk, input protCfg_t c);
    logic [9:0] span;
    logic       hit;
    span = spanBlocks(c.bp);
    hit  = c.tb ? ({1'b0, blk} < span)
                : ({1'b0, blk} >= 10'(BLOCKS_ALL) - span);
    return hit ^ c.cmp;
  endfunction : bpProt

  function automatic logic isReadOp(input logic [7:0] op);
    return (op == OP_RDSR1) || (op == OP_RDSR2) || (op == OP_RDSR3);
  endfunction : isReadOp

  // ****************************************************************
  // pin synchronisation and edges
  // ****************************************************************
  pinSet_t pinRaw;
  pinSet_t pinS;
  logic    sclkPrev_q;
  logic    csPrev_q;
  logic    sclkRise;
  logic    sclkFall;
  logic    frameEnd;

  assign pinRaw = '{csN: csN, sclk: sclk, mosi: mosi, wpN: wpN};

  // reset to idle levels: deselected, clock low, pin released high
  pin_sync #(
    .W       ($bits(pinSet_t)),
    .RST_VAL (pinSet_t'{csN: 1'b1, sclk: 1'b0, mosi: 1'b0, wpN: 1'b1})
  ) uSync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (pinRaw),
    .dout    (pinS)
  );

  // previous levels for edge finding
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else begin
      sclkPrev_q <= pinS.sclk;
      csPrev_q   <= pinS.csN;
    end
  end

  assign sclkRise = !pinS.csN && pinS.sclk && !sclkPrev_q;
  assign sclkFall = !pinS.csN && !pinS.sclk && sclkPrev_q;
  assign frameEnd = pinS.csN && !csPrev_q;

  // ****************************************************************
  // instruction capture
  // ****************************************************************
  logic [5:0]        bitCnt_q;
  logic [31:0]       sh_q;
  logic [31:0]       shNext;
  logic [7:0]        opc_q;
  logic [7:0]        dat_q;
  logic [ADDR_W-1:0] addr_q;

  assign shNext = {sh_q[30:0], pinS.mosi};

  // count saturates so long program frames do not wrap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_q <= '0;
      sh_q     <= '0;
      opc_q    <= '0;
      dat_q    <= '0;
      addr_q   <= '0;
    end else if (pinS.csN) begin
      bitCnt_q <= '0;
    end else if (sclkRise) begin
      sh_q     <= shNext;
      bitCnt_q <= (bitCnt_q == 6'h3F) ? bitCnt_q : bitCnt_q + 6'h01;
      if (bitCnt_q == 6'h07) opc_q <= shNext[7:0];
      if (bitCnt_q == 6'h0F) dat_q <= shNext[7:0];
      if (bitCnt_q == 6'h27) addr_q <= shNext[ADDR_W-1:0];
    end
  end

  // ****************************************************************
  // decode and acceptance
  // ****************************************************************
  mode_t           mode_q;
  mode_t           mode_d;
  protCfg_t        prot_q;
  logic            wel_q;
  logic            rstEn_q;
  logic            suspendable_q;
  logic [15:0]     opCnt_q;
  logic [15:0]     opCnt_d;
  logic [15:0]     puwCnt_q;
  logic [LOCK_BITS-1:0] lock_q;
  logic isWrsr;
  logic isArray;
  logic isWrite;
  logic needAddr;
  logic lenOk;
  logic puwActive;
  logic accept;
  logic srWriteOk;
  logic arrayOk;
  logic anyProt;
  logic startOp;
  logic rstGo;
  logic [15:0] startCyc;

  assign isWrsr   = (opc_q == OP_WRSR1) || (opc_q == OP_WRSR2) || (opc_q == OP_WRSR3);
  assign isArray  = (opc_q == OP_PP) || (opc_q == OP_QPP) || (opc_q == OP_SE)
                  || (opc_q == OP_BE) || (opc_q == OP_CE) || (opc_q == OP_CE_ALT);
  assign isWrite  = isWrsr || isArray || (opc_q == OP_ERSEC) || (opc_q == OP_PRSEC);
  assign needAddr = (isArray && opc_q != OP_CE && opc_q != OP_CE_ALT)
                  || (opc_q == OP_ERSEC) || (opc_q == OP_PRSEC) || (opc_q == OP_UNLOCK);
  assign lenOk    = (bitCnt_q[2:0] == 3'h0) && (bitCnt_q >= 6'h08)
                  && (!needAddr || bitCnt_q >= 6'h28) && (!isWrsr || bitCnt_q >= 6'h10);
  assign puwActive = (puwCnt_q != 16'h0000);

  // filtering per mode; reset period takes nothing
  assign accept = frameEnd && lenOk && (
      (mode_q == MODE_READY && !(puwActive && (opc_q == OP_WREN || isWrite)))
   || (mode_q == MODE_BUSY  && (isReadOp(opc_q) || opc_q == OP_SUSPEND))
   || (mode_q == MODE_SUSP  && !isWrite && opc_q != OP_PDOWN
                            && opc_q != OP_RSTEN && opc_q != OP_RST)
   || (mode_q == MODE_PDOWN && opc_q == OP_RELEASE));

  // status write gate: lock-down always, protect bit with pin low
  assign srWriteOk = !prot_q.status_lockdown_bit && !(prot_q.status_protect_bit && !pinS.wpN);

  // chip erase needs the whole array free
  assign anyProt = prot_q.protect_scheme_select ? (|lock_q)
                 : (prot_q.cmp ? (spanBlocks(prot_q.bp) != 10'(BLOCKS_ALL))
                               : (spanBlocks(prot_q.bp) != 10'h000));
  assign arrayOk = !isArray ? 1'b1
                 : (opc_q == OP_CE || opc_q == OP_CE_ALT) ? !anyProt
                 : prot_q.protect_scheme_select ? !lock_q[regionIndex(addr_q)]
                 : !bpProt(addr_q[ADDR_W-1:16], prot_q);

  assign startOp  = accept && isWrite && wel_q && (isWrsr ? srWriteOk : arrayOk);
  assign startCyc = isWrsr ? 16'(WRSR_CYC)
                  : (opc_q == OP_PP || opc_q == OP_QPP || opc_q == OP_PRSEC) ? 16'(PROG_CYC)
                  : 16'(ERASE_CYC);
  assign rstGo    = accept && rstEn_q && (opc_q == OP_RST);

  // ****************************************************************
  // operating mode
  // ****************************************************************
  // busy and reset both count down on one timer
  always_comb begin
    mode_d  = mode_q;
    opCnt_d = opCnt_q;
    case (mode_q)
      MODE_READY: begin
        if (startOp) begin
          mode_d  = MODE_BUSY;
          opCnt_d = startCyc;
        end else if (rstGo) begin
          mode_d  = MODE_RESET;
          opCnt_d = 16'(RST_CYC);
        end else if (accept && opc_q == OP_PDOWN) begin
          mode_d = MODE_PDOWN;
        end
      end
      MODE_BUSY: begin
        if (accept && opc_q == OP_SUSPEND && suspendable_q) begin
          mode_d = MODE_SUSP;
        end else if (opCnt_q <= 16'h0001) begin
          mode_d = MODE_READY;
        end else begin
          opCnt_d = opCnt_q - 16'h0001;
        end
      end
      MODE_SUSP: begin
        if (accept && opc_q == OP_RESUME) mode_d = MODE_BUSY;
      end
      MODE_PDOWN: begin
        if (accept && opc_q == OP_RELEASE) mode_d = MODE_READY;
      end
      MODE_RESET: begin
        if (opCnt_q <= 16'h0001) mode_d = MODE_READY;
        else opCnt_d = opCnt_q - 16'h0001;
      end
      default: begin
        mode_d  = MODE_READY;
        opCnt_d = 16'h0000;
      end
    endcase
  end

  // held in reset: no mode change, no operation
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q  <= MODE_READY;
      opCnt_q <= 16'h0000;
    end else begin
      mode_q  <= mode_d;
      opCnt_q <= opCnt_d;
    end
  end

  // suspend only applies to program and erase work
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) suspendable_q <= 1'b0;
    else if (startOp) suspendable_q <= !isWrsr;
  end

  // reset enable arms only the very next frame
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rstEn_q <= 1'b0;
    else if (frameEnd) rstEn_q <= accept && (opc_q == OP_RSTEN);
  end

  // power-up inhibit timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) puwCnt_q <= 16'(PUW_CYC);
    else if (puwActive) puwCnt_q <= puwCnt_q - 16'h0001;
  end

  // ****************************************************************
  // write enable latch and protection settings
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) wel_q <= 1'b0;
    else if (rstGo) wel_q <= 1'b0;
    else if (accept && opc_q == OP_WREN) wel_q <= 1'b1;
    else if (accept && (opc_q == OP_WRDI || isWrite)) wel_q <= 1'b0;
  end

  // settings change when the write starts, not at its end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_q <= PROT_RESET;
    end else if (startOp && opc_q == OP_WRSR1) begin
      prot_q.bp  <= dat_q[BP_LSB +: 4];
      prot_q.tb  <= dat_q[TB_POS];
      prot_q.status_protect_bit <= dat_q[SRP_POS];
    end else if (startOp && opc_q == OP_WRSR2) begin
      prot_q.status_lockdown_bit <= dat_q[SRL_POS];
      prot_q.cmp <= dat_q[CMP_POS];
    end else if (startOp && opc_q == OP_WRSR3) begin
      prot_q.protect_scheme_select <= dat_q[WPS_POS];
    end
  end

  // ****************************************************************
  // individual lock bits
  // ****************************************************************
  // array is fully locked after power-on and software reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) lock_q <= '1;
    else if (rstGo) lock_q <= '1;
    else if (accept && opc_q == OP_UNLOCK) lock_q[regionIndex(addr_q)] <= 1'b0;
  end

  // ****************************************************************
  // status readout
  // ****************************************************************
  logic [7:0] statusTwo;
  logic [7:0] statusThree;
  logic [7:0] statusOneNow;
  logic [7:0] outSh_q;
  logic [7:0] rdByte;
  logic       rdLoad;
  logic       miso_q;

  assign statusOneNow = {prot_q.status_protect_bit, prot_q.tb, prot_q.bp, wel_q,
                         mode_q == MODE_BUSY};
  assign statusTwo    = {mode_q == MODE_SUSP, prot_q.cmp, 5'h00, prot_q.status_lockdown_bit};
  assign statusThree  = {5'h00, prot_q.protect_scheme_select, 2'h0};
  assign rdByte = (shNext[7:0] == OP_RDSR2) ? statusTwo
                : (shNext[7:0] == OP_RDSR3) ? statusThree : statusOneNow;
  // read is taken at the eighth rising edge; closed in power-down and reset
  assign rdLoad = sclkRise && bitCnt_q == 6'h07 && isReadOp(shNext[7:0])
               && mode_q != MODE_PDOWN && mode_q != MODE_RESET;

  // byte repeats so a long read keeps showing the status taken at the eighth rising edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      outSh_q <= '0;
      miso_q  <= 1'b0;
    end else if (rdLoad) begin
      outSh_q <= rdByte;
    end else if (sclkFall) begin
      miso_q  <= outSh_q[7];
      outSh_q <= {outSh_q[6:0], outSh_q[7]};
    end
  end

  // observation outputs lag the state by one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusOne <= 8'h00;
      powerDown <= 1'b0;
    end else begin
      statusOne <= statusOneNow;
      powerDown <= (mode_q == MODE_PDOWN);
    end
  end

  assign miso = miso_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  puw_blocks_wel_a: assert property (frameEnd && puwActive && opc_q == OP_WREN
    && mode_q == MODE_READY |=> !wel_q) else $error("enable taken during inhibit");
  wel_needed_a: assert property (startOp |-> wel_q)
    else $error("write started without latch");
  wel_set_a: assert property (accept && opc_q == OP_WREN && !rstGo |=> wel_q ##1 statusOne[WEL_POS])
    else $error("latch not set by enable");
  wel_clear_a: assert property (accept && (opc_q == OP_WRDI || isWrite) |=> !wel_q)
    else $error("latch not cleared");
  busy_start_a: assert property (startOp |=> mode_q == MODE_BUSY ##1 statusOne[BUSY_POS])
    else $error("busy not raised");
  busy_end_a: assert property (mode_q == MODE_BUSY && opCnt_q == 16'h0001 && !accept
    |=> mode_q == MODE_READY) else $error("busy not released");
  busy_filter_a: assert property (mode_q == MODE_BUSY && frameEnd && !isReadOp(opc_q)
    && opc_q != OP_SUSPEND |-> !accept) else $error("busy took an instruction");
  pdown_filter_a: assert property (mode_q == MODE_PDOWN && opc_q != OP_RELEASE |-> !accept)
    else $error("power-down took an instruction");
  lock_guard_a: assert property (startOp && isArray && prot_q.protect_scheme_select && needAddr
    |-> !lock_q[regionIndex(addr_q)]) else $error("locked region written");
  range_guard_a: assert property (startOp && isArray && !prot_q.protect_scheme_select && needAddr
    |-> !bpProt(addr_q[ADDR_W-1:16], prot_q)) else $error("protected range written");
  sr_gate_a: assert property (startOp && isWrsr |-> !prot_q.status_lockdown_bit && (!prot_q.status_protect_bit || pinS.wpN))
    else $error("status write not gated");
  unlock_bit_a: assert property (accept && opc_q == OP_UNLOCK |=> !lock_q[regionIndex(addr_q)])
    else $error("lock bit not cleared");
  relock_a: assert property (rstGo |=> (&lock_q) && mode_q == MODE_RESET)
    else $error("reset left locks open");

  write_run_c:  cover property (startOp ##[1:1000] mode_q == MODE_READY);
  suspend_c:    cover property (mode_q == MODE_BUSY ##1 mode_q == MODE_SUSP);
  soft_reset_c: cover property (rstGo);
  unlock_c:     cover property (accept && opc_q == OP_UNLOCK);

endmodule : flash_write_protect_status
`default_nettype wire

// *** testbench/spi_host_model.sv ***
// SPI host model that frames instructions for the flash protection block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // serial pins
  output var  logic csN,
  output var  logic sclk,
  output var  logic mosi,
  input  wire logic miso
);
  // idle bus: deselected, mode 0 clock parked low
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // one frame, msb first, tx left-justified; sclk stands still between frames
  task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[39-i];
      #24 sclk = 1'b1;
      rx = {rx[38:0], miso};
      #24 sclk = 1'b0;
    end
    #24 csN = 1'b1;
    mosi = ~mosi; // stale data bit never survives a frame
    #240;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// *** testbench/flash_write_protect_status_bench.sv ***
// Self-checking bench for the flash write-protection and status block
`timescale 1ns/1ps
`default_nettype none
module flash_write_protect_status_bench
  import flash_wp_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        wpN     = 1'b1;
  logic [39:0] rx;
  wire  logic  csN, sclk, mosi, miso, powerDown;
  wire  logic [7:0] statusOne;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  // rows: status one, status two, busy expected, erase address
  logic [41:0] rows [5] = '{{8'h04, 8'h00, 1'b0, 25'h1FF0000}, {8'h04, 8'h00, 1'b1, 25'h0},
    {8'h44, 8'h00, 1'b0, 25'h0}, {8'h44, 8'h40, 1'b1, 25'h0},
    {8'h44, 8'h40, 1'b0, 25'h1FF0000}};
  // short busy counts keep the run brief
  flash_write_protect_status #(.PROG_CYC(100), .ERASE_CYC(300), .WRSR_CYC(200),
    .RST_CYC(100)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .csN(csN), .sclk(sclk),
    .mosi(mosi), .wpN(wpN), .miso(miso), .statusOne(statusOne), .powerDown(powerDown));
  spi_host_model host (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso));
  always #2.5 ref_clk = ~ref_clk;
  // hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [39:0] tx, input int n);
    host.frame(tx, n, rx);
  endtask : cmd
  // bounded wait for the busy flag to drop
  task automatic idle();
    for (int k = 0; k < 3000 && statusOne[0] !== 1'b0; k++) @(negedge ref_clk);
  endtask : idle
  task automatic wrsr(input logic [7:0] op, input logic [7:0] d);
    cmd({OP_WREN, 32'h0}, 8);
    cmd({op, d, 24'h0}, 16);
    idle();
  endtask : wrsr
  task automatic erase(input logic [24:0] a);
    cmd({OP_WREN, 32'h0}, 8);
    cmd({OP_SE, 7'h0, a}, 40);
  endtask : erase
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    check(statusOne, 8'h00);
    cmd({OP_WREN, 32'h0}, 8);
    check(statusOne, 8'h00);
    repeat (PUW_CYC) @(negedge ref_clk);
    cmd({OP_WRSR1, 8'h04, 24'h0}, 16);
    check(statusOne, 8'h00);
    cmd({OP_WREN, 32'h0}, 8);
    cmd({OP_RDSR1, 32'h0}, 16);
    check(rx[7:0], 8'h02);
    cmd({OP_WRDI, 32'h0}, 8);
    check(statusOne, 8'h00);
    cmd({OP_WREN, 32'h0}, 8);
    cmd({OP_WRSR1, 8'h07, 24'h0}, 16);
    check(statusOne, 8'h05);
    cmd({OP_WREN, 32'h0}, 8);
    check(statusOne, 8'h05);
    idle();
    check(statusOne, 8'h04);
    $display("test latch and busy done");
    foreach (rows[i]) begin
      wrsr(OP_WRSR1, rows[i][41:34]);
      wrsr(OP_WRSR2, rows[i][33:26]);
      erase(rows[i][24:0]);
      check({7'h0, statusOne[0]}, {7'h0, rows[i][25]});
      idle();
      check({7'h0, statusOne[1]}, 8'h00);
    end
    $display("test range protection done");
    wrsr(OP_WRSR2, 8'h00);
    wrsr(OP_WRSR1, 8'h3C);
    wrsr(OP_WRSR3, 8'h04);
    erase(25'h0010000);
    check({7'h0, statusOne[0]}, 8'h00);
    cmd({OP_UNLOCK, 7'h0, 25'h0010000}, 40);
    erase(25'h0010000);
    check({7'h0, statusOne[0]}, 8'h01);
    idle();
    erase(25'h0020000);
    check({7'h0, statusOne[0]}, 8'h00);
    cmd({OP_RSTEN, 32'h0}, 8);
    cmd({OP_RST, 32'h0}, 8);
    repeat (300) @(negedge ref_clk);
    erase(25'h0010000);
    check({7'h0, statusOne[0]}, 8'h00);
    $display("test block locks done");
    cmd({OP_PDOWN, 32'h0}, 8);
    check({7'h0, powerDown}, 8'h01);
    cmd({OP_WREN, 32'h0}, 8);
    check({7'h0, statusOne[1]}, 8'h00);
    cmd({OP_RELEASE, 32'h0}, 8);
    check({7'h0, powerDown}, 8'h00);
    wrsr(OP_WRSR1, 8'hBC);
    @(negedge ref_clk) wpN = 1'b0;
    wrsr(OP_WRSR1, 8'h80);
    check(statusOne, 8'hBC);
    @(negedge ref_clk) wpN = 1'b1;
    wrsr(OP_WRSR1, 8'h80);
    check(statusOne, 8'h80);
    $display("test power-down and status gating done");
    @(negedge ref_clk) arst_n = 1'b0;
    cmd({OP_WREN, 32'h0}, 8);
    @(negedge ref_clk) arst_n = 1'b1;
    check(statusOne, 8'h00);
    $display("test second reset done");
    stop_test();
  end
endmodule : flash_write_protect_status_bench
`default_nettype wire
